// ==== hdl/rss_pkg.sv ====
// Constants and types shared by the rotate/subtract/skip datapath.
// Assumes one core clock; operations arrive one per machine cycle.
package rss_pkg;
	localparam int RSS_DW = 8;
	localparam logic [7:0] RSS_ACC_RST = 8'h00;
	localparam logic [7:0] RSS_ALL_ONES = 8'hFF;
	localparam logic [7:0] RSS_ONE = 8'h01;
	localparam int RSS_MSB = 7;
	localparam int RSS_NIB = 4;
	localparam int RSS_AUX = 4;
	localparam int RSS_SKIP_CYCLES = 2;
	// Operation codes on the op port
	typedef enum logic [4:0] {
		RSS_OP_NONE,
		RSS_OP_RLC_MEM,
		RSS_OP_RLC_ACC,
		RSS_OP_RL_ACC,
		RSS_OP_RR_MEM,
		RSS_OP_RR_ACC,
		RSS_OP_RRC_MEM,
		RSS_OP_RRC_ACC,
		RSS_OP_SBB_ACC,
		RSS_OP_SBB_MEM,
		RSS_OP_SUB_ACC,
		RSS_OP_SUB_MEM,
		RSS_OP_SUB_IMM,
		RSS_OP_DSZ_MEM,
		RSS_OP_DSZ_ACC,
		RSS_OP_ISZ_MEM,
		RSS_OP_ISZ_ACC,
		RSS_OP_SKIP_BIT,
		RSS_OP_SET_BYTE,
		RSS_OP_SET_BIT,
		RSS_OP_SWAP_MEM
	} rss_op_e;
	// Issue state: normal or dummy cycle after taken skip
	typedef enum logic [0:0] {
		RSS_ST_RUN,
		RSS_ST_DUMMY
	} rss_state_e;
endpackage

// ==== hdl/rss_sub.sv ====
// Subtracter a + ~b + cin with overflow, zero, aux and carry.
// Assumes purely combinational use inside the datapath.
module rss_sub
	import rss_pkg::*;
#(
	parameter int W = RSS_DW
) (
	// Operands
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic cin,
	// Result and flags
	output logic [W-1:0] res,
	output logic ov,
	output logic z,
	output logic ac,
	output logic cy
);
	logic [W:0] sum;
	logic [RSS_AUX:0] low;
	// Full and low-nibble sums
	always_comb begin
		sum = {1'b0, a} + {1'b0, ~b} + {{W{1'b0}}, cin};
		low = {1'b0, a[RSS_AUX-1:0]} + {1'b0, ~b[RSS_AUX-1:0]} + {{RSS_AUX{1'b0}}, cin};
		res = sum[W-1:0];
		cy = sum[W];
		ac = low[RSS_AUX];
		z = (sum[W-1:0] == '0);
		ov = (a[W-1] == ~b[W-1]) && (sum[W-1] != a[W-1]);
	end
endmodule

// ==== hdl/rss_skip.sv ====
// Skip sequencer: a taken skip squashes the fetched next op for one dummy cycle.
// Assumes op_valid marks each op the fetch stage hands over.
module rss_skip
	import rss_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Decision from the datapath
	input wire logic take,
	// Dummy-cycle marker
	output logic dummy_q
);
	rss_state_e state_q;
	// One dummy cycle follows each taken skip
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= RSS_ST_RUN;
		end else begin
			case (state_q)
				RSS_ST_RUN: state_q <= take ? RSS_ST_DUMMY : RSS_ST_RUN; // see RQ10
				RSS_ST_DUMMY: state_q <= RSS_ST_RUN;
				default: state_q <= RSS_ST_RUN;
			endcase
		end
	end
	assign dummy_q = (state_q == RSS_ST_DUMMY);
endmodule

// ==== hdl/rss_datapath.sv ====
// Datapath for rotate, subtract, skip, set and swap operations.
// Assumes memory byte and operand arrive with op; writes go out registered.
// Function
// RQ1: Rotate left through carry to memory; old carry to bit 0, bit 7 to carry.
// RQ2: Rotate left through carry into accumulator; carry from bit 7; memory kept.
// RQ3: Rotate right memory, bit 0 into bit 7, flags kept.
// RQ4: Rotate right into accumulator, bit 0 into bit 7, memory and flags kept.
// RQ5: Rotate right through carry to memory; carry to bit 7, bit 0 to carry.
// RQ6: Rotate right through carry into accumulator; carry from bit 0.
// RQ7: Subtract with borrow acc + ~m + carry to acc or memory, four flags.
// RQ8: Subtract acc + ~m + 1 to acc or memory, four flags updated.
// RQ9: Immediate subtract acc + ~imm + 1 into acc, four flags updated.
// RQ10: Taken skip discards fetched op with dummy cycle: two cycles, else one.
// RQ11: Decrement memory, write back, skip when zero, flags kept.
// RQ12: Decrement into accumulator, memory kept, skip when zero.
// RQ13: Increment memory, write back, skip when wrapped zero, flags kept.
// RQ14: Increment into accumulator, memory kept, skip when zero.
// RQ15: Skip when selected memory bit is one; nothing modified.
// RQ16: Set byte writes all ones; set bit forces one bit; no flags.
// RQ17: Set bit writes only the selected position, other bits kept.
// RQ18: Swap nibbles of memory byte in place, no flags.
// RQ19: Rotate left into accumulator, bit 7 into bit 0, memory and flags kept.
// RQ20: Every op completes in one cycle; only taken skip adds a dummy.
// RQ21: Rotate-through-carry uses operand and carry as sampled at op start.
module rss_datapath
	import rss_pkg::*;
#(
	parameter int W = RSS_DW
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Operation issue
	input wire logic op_valid,
	input wire rss_op_e op,
	input wire logic [2:0] bit_sel,
	input wire logic [W-1:0] mem_rdata,
	input wire logic [W-1:0] imm,
	// Memory write-back
	output logic mem_we_q,
	output logic [W-1:0] mem_wdata_q,
	// Architectural state
	output logic [W-1:0] accumulator_q,
	output logic carry_flag_q,
	output logic zero_flag_q,
	output logic aux_carry_flag_q,
	output logic overflow_flag_q,
	// Fetch squash for the dummy cycle
	output logic squash_q,
	output logic busy_q
);
	logic go;
	logic dummy;
	logic [W-1:0] sub_b;
	logic sub_cin;
	logic [W-1:0] sub_res;
	logic s_ov, s_z, s_ac, s_cy;
	logic [W-1:0] res;
	logic [W-1:0] dec_v, inc_v;
	logic wr_acc, wr_mem, wr_cy, wr_arith, take;
	logic next_cy;

	// An op fetched under a taken skip is dropped
	assign go = op_valid && !dummy; // see RQ10

	// Subtracter operand selection
	always_comb begin
		sub_b = (op == RSS_OP_SUB_IMM) ? imm : mem_rdata; // see RQ9
		sub_cin = (op == RSS_OP_SBB_ACC || op == RSS_OP_SBB_MEM) ? carry_flag_q : 1'b1; // see RQ7
	end

	rss_sub #(
		.W(W)
	) u_sub (
		.a(accumulator_q),
		.b(sub_b),
		.cin(sub_cin),
		.res(sub_res),
		.ov(s_ov),
		.z(s_z),
		.ac(s_ac),
		.cy(s_cy)
	);

	assign dec_v = mem_rdata - RSS_ONE;
	assign inc_v = mem_rdata + RSS_ONE;

	// Result, destination and skip decode
	always_comb begin
		res = mem_rdata;
		wr_acc = 1'b0;
		wr_mem = 1'b0;
		wr_cy = 1'b0;
		wr_arith = 1'b0;
		take = 1'b0;
		next_cy = carry_flag_q;
		case (op)
			RSS_OP_RLC_MEM: begin
				res = {mem_rdata[W-2:0], carry_flag_q}; // see RQ1
				next_cy = mem_rdata[W-1]; // see RQ21
				wr_mem = 1'b1;
				wr_cy = 1'b1;
			end
			RSS_OP_RLC_ACC: begin
				res = {mem_rdata[W-2:0], carry_flag_q}; // see RQ2
				next_cy = mem_rdata[W-1];
				wr_acc = 1'b1;
				wr_cy = 1'b1;
			end
			RSS_OP_RL_ACC: begin
				res = {mem_rdata[W-2:0], mem_rdata[W-1]}; // see RQ19
				wr_acc = 1'b1;
			end
			RSS_OP_RR_MEM: begin
				res = {mem_rdata[0], mem_rdata[W-1:1]}; // see RQ3
				wr_mem = 1'b1;
			end
			RSS_OP_RR_ACC: begin
				res = {mem_rdata[0], mem_rdata[W-1:1]}; // see RQ4
				wr_acc = 1'b1;
			end
			RSS_OP_RRC_MEM: begin
				res = {carry_flag_q, mem_rdata[W-1:1]}; // see RQ5
				next_cy = mem_rdata[0]; // see RQ21
				wr_mem = 1'b1;
				wr_cy = 1'b1;
			end
			RSS_OP_RRC_ACC: begin
				res = {carry_flag_q, mem_rdata[W-1:1]}; // see RQ6
				next_cy = mem_rdata[0];
				wr_acc = 1'b1;
				wr_cy = 1'b1;
			end
			RSS_OP_SBB_ACC, RSS_OP_SUB_ACC, RSS_OP_SUB_IMM: begin
				res = sub_res; // see RQ8
				wr_acc = 1'b1;
				wr_arith = 1'b1;
			end
			RSS_OP_SBB_MEM, RSS_OP_SUB_MEM: begin
				res = sub_res; // see RQ7
				wr_mem = 1'b1;
				wr_arith = 1'b1;
			end
			RSS_OP_DSZ_MEM: begin
				res = dec_v; // see RQ11
				wr_mem = 1'b1;
				take = (dec_v == '0);
			end
			RSS_OP_DSZ_ACC: begin
				res = dec_v; // see RQ12
				wr_acc = 1'b1;
				take = (dec_v == '0);
			end
			RSS_OP_ISZ_MEM: begin
				res = inc_v; // see RQ13
				wr_mem = 1'b1;
				take = (inc_v == '0);
			end
			RSS_OP_ISZ_ACC: begin
				res = inc_v; // see RQ14
				wr_acc = 1'b1;
				take = (inc_v == '0);
			end
			RSS_OP_SKIP_BIT: begin
				take = mem_rdata[bit_sel]; // see RQ15
			end
			RSS_OP_SET_BYTE: begin
				res = RSS_ALL_ONES; // see RQ16
				wr_mem = 1'b1;
			end
			RSS_OP_SET_BIT: begin
				res = mem_rdata | (RSS_ONE << bit_sel); // see RQ17
				wr_mem = 1'b1;
			end
			RSS_OP_SWAP_MEM: begin
				res = {mem_rdata[RSS_NIB-1:0], mem_rdata[W-1:RSS_NIB]}; // see RQ18
				wr_mem = 1'b1;
			end
			default: begin
				res = mem_rdata;
			end
		endcase
	end

	// Skip sequencer
	rss_skip u_skip (
		.clock(clock),
		.rst(rst),
		.take(go && take),
		.dummy_q(dummy)
	);

	// Accumulator update
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			accumulator_q <= RSS_ACC_RST;
		end else if (go && wr_acc) begin
			accumulator_q <= res; // see RQ20
		end
	end

	// Memory write strobe and data, one cycle per op
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_we_q <= 1'b0;
			mem_wdata_q <= RSS_ACC_RST;
		end else begin
			mem_we_q <= go && wr_mem;
			if (go && wr_mem) begin
				mem_wdata_q <= res;
			end
		end
	end

	// Carry flag from rotates or subtracter
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			carry_flag_q <= 1'b0;
		end else if (go && wr_arith) begin
			carry_flag_q <= s_cy; // see RQ7
		end else if (go && wr_cy) begin
			carry_flag_q <= next_cy; // see RQ21
		end
	end

	// Overflow, zero and aux carry only from subtracts
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			overflow_flag_q <= 1'b0;
			zero_flag_q <= 1'b0;
			aux_carry_flag_q <= 1'b0;
		end else if (go && wr_arith) begin
			overflow_flag_q <= s_ov; // see RQ8
			zero_flag_q <= s_z;
			aux_carry_flag_q <= s_ac;
		end
	end

	// Squash marker mirrors the dummy cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			squash_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			squash_q <= go && take; // see RQ10
			busy_q <= go && take;
		end
	end

	// Checks
	rot_carry_a: assert property (@(posedge clock) disable iff (rst)
		go && op == RSS_OP_RLC_MEM |=> carry_flag_q == $past(mem_rdata[W-1])
			&& mem_wdata_q[0] == $past(carry_flag_q)) // see RQ1
		else $error("rotate left carry mismatch");
	rrc_acc_a: assert property (@(posedge clock) disable iff (rst)
		go && op == RSS_OP_RRC_ACC |=> accumulator_q[W-1] == $past(carry_flag_q)
			&& carry_flag_q == $past(mem_rdata[0]) && !mem_we_q) // see RQ6
		else $error("rotate right carry acc mismatch");
	rr_flags_a: assert property (@(posedge clock) disable iff (rst)
		go && (op == RSS_OP_RR_MEM || op == RSS_OP_RR_ACC) |=> $stable(carry_flag_q)
			&& $stable(zero_flag_q)) // see RQ3
		else $error("rotate right touched flags");
	rl_acc_a: assert property (@(posedge clock) disable iff (rst)
		go && op == RSS_OP_RL_ACC |=> accumulator_q == {$past(mem_rdata[W-2:0]),
			$past(mem_rdata[W-1])} && !mem_we_q) // see RQ19
		else $error("rotate left acc mismatch");
	sub_result_a: assert property (@(posedge clock) disable iff (rst)
		go && op == RSS_OP_SUB_ACC |=> accumulator_q == $past(accumulator_q - mem_rdata)
			&& zero_flag_q == (accumulator_q == '0)) // see RQ8
		else $error("subtract result mismatch");
	skip_dummy_a: assert property (@(posedge clock) disable iff (rst)
		go && take |=> dummy ##1 !dummy) // see RQ10
		else $error("skip dummy cycle wrong");
	no_skip_a: assert property (@(posedge clock) disable iff (rst)
		go && !take |=> !dummy) // see RQ20
		else $error("unexpected dummy cycle");
	dsz_zero_a: assert property (@(posedge clock) disable iff (rst)
		go && op == RSS_OP_DSZ_MEM && mem_rdata == RSS_ONE |=> mem_we_q
			&& mem_wdata_q == '0 && squash_q) // see RQ11
		else $error("decrement skip mismatch");
	set_bit_a: assert property (@(posedge clock) disable iff (rst)
		go && op == RSS_OP_SET_BIT |=> mem_wdata_q[$past(bit_sel)]
			&& (mem_wdata_q | (RSS_ONE << $past(bit_sel))) ==
			($past(mem_rdata) | (RSS_ONE << $past(bit_sel)))) // see RQ17
		else $error("set bit mismatch");
	swap_nib_a: assert property (@(posedge clock) disable iff (rst)
		go && op == RSS_OP_SWAP_MEM |=> mem_wdata_q == {$past(mem_rdata[RSS_NIB-1:0]),
			$past(mem_rdata[W-1:RSS_NIB])}) // see RQ18
		else $error("swap mismatch");
	skip_taken_c: cover property (@(posedge clock) go && take ##1 dummy);
	sub_borrow_c: cover property (@(posedge clock) go && op == RSS_OP_SBB_MEM && !carry_flag_q);
	isz_wrap_c: cover property (@(posedge clock) go && op == RSS_OP_ISZ_ACC && take);
endmodule

// ==== test/tb_rss_datapath.sv ====
// Self-checking bench for the rotate/subtract/skip datapath.
// Assumes rss_pkg is compiled first; the bench drives every port itself.
module tb_rss_datapath
	import rss_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// Design ports
	logic clock;
	logic rst;
	logic op_valid;
	rss_op_e op;
	logic [2:0] bit_sel;
	logic [7:0] mem_rdata;
	logic [7:0] imm;
	logic mem_we_q;
	logic [7:0] mem_wdata_q;
	logic [7:0] accumulator_q;
	logic carry_flag_q;
	logic zero_flag_q;
	logic aux_carry_flag_q;
	logic overflow_flag_q;
	logic squash_q;
	logic busy_q;

	// Reference state and pending expectation
	logic [7:0] m_acc;
	logic m_c;
	logic m_z;
	logic m_ac;
	logic m_ov;
	logic m_dummy;
	logic e_we;
	logic e_sq;
	logic [7:0] e_wd;
	int error_cnt;
	int comparisons;
	int seed;

	rss_datapath dut (
		.clock(clock),
		.rst(rst),
		.op_valid(op_valid),
		.op(op),
		.bit_sel(bit_sel),
		.mem_rdata(mem_rdata),
		.imm(imm),
		.mem_we_q(mem_we_q),
		.mem_wdata_q(mem_wdata_q),
		.accumulator_q(accumulator_q),
		.carry_flag_q(carry_flag_q),
		.zero_flag_q(zero_flag_q),
		.aux_carry_flag_q(aux_carry_flag_q),
		.overflow_flag_q(overflow_flag_q),
		.squash_q(squash_q),
		.busy_q(busy_q)
	);

	// Reference model: advances state by one accepted op
	function automatic void predict(rss_op_e o, logic v, logic [7:0] m, logic [7:0] x,
		logic [2:0] b);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		logic c;
		e_we = 1'b0;
		e_sq = 1'b0;
		if (m_dummy || !v) begin
			m_dummy = 1'b0;
			return;
		end
		c = (o == RSS_OP_SBB_ACC || o == RSS_OP_SBB_MEM) ? m_c : 1'b1;
		if (o == RSS_OP_SUB_IMM) begin
			m = x;
		end
		r = m;
		s = {1'b0, m_acc} + {1'b0, ~m} + 9'(c);
		h = {1'b0, m_acc[3:0]} + {1'b0, ~m[3:0]} + 5'(c);
		case (o)
			RSS_OP_RLC_MEM, RSS_OP_RLC_ACC: begin
				r = {m[6:0], m_c};
				m_c = m[7];
			end
			RSS_OP_RL_ACC: r = {m[6:0], m[7]};
			RSS_OP_RR_MEM, RSS_OP_RR_ACC: r = {m[0], m[7:1]};
			RSS_OP_RRC_MEM, RSS_OP_RRC_ACC: begin
				r = {m_c, m[7:1]};
				m_c = m[0];
			end
			RSS_OP_SBB_ACC, RSS_OP_SBB_MEM, RSS_OP_SUB_ACC, RSS_OP_SUB_MEM,
			RSS_OP_SUB_IMM: begin
				r = s[7:0];
				m_c = s[8];
				m_ac = h[4];
				m_z = (r == 8'h00);
				m_ov = (m_acc[7] != m[7]) && (r[7] != m_acc[7]);
			end
			RSS_OP_DSZ_MEM, RSS_OP_DSZ_ACC: r = m - 8'h01;
			RSS_OP_ISZ_MEM, RSS_OP_ISZ_ACC: r = m + 8'h01;
			RSS_OP_SKIP_BIT: e_sq = m[b];
			RSS_OP_SET_BYTE: r = 8'hFF;
			RSS_OP_SET_BIT: r[b] = 1'b1;
			RSS_OP_SWAP_MEM: r = {m[3:0], m[7:4]};
			default: ;
		endcase
		if (o inside {RSS_OP_DSZ_MEM, RSS_OP_DSZ_ACC, RSS_OP_ISZ_MEM, RSS_OP_ISZ_ACC}) begin
			e_sq = (r == 8'h00);
		end
		if (o inside {RSS_OP_RLC_ACC, RSS_OP_RL_ACC, RSS_OP_RR_ACC, RSS_OP_RRC_ACC,
			RSS_OP_SBB_ACC, RSS_OP_SUB_ACC, RSS_OP_SUB_IMM, RSS_OP_DSZ_ACC,
			RSS_OP_ISZ_ACC}) begin
			m_acc = r;
		end
		if (o inside {RSS_OP_RLC_MEM, RSS_OP_RR_MEM, RSS_OP_RRC_MEM, RSS_OP_SBB_MEM,
			RSS_OP_SUB_MEM, RSS_OP_DSZ_MEM, RSS_OP_ISZ_MEM, RSS_OP_SET_BYTE,
			RSS_OP_SET_BIT, RSS_OP_SWAP_MEM}) begin
			e_we = 1'b1;
			e_wd = r;
		end
		m_dummy = e_sq;
	endfunction

	// Compare one value and count it
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Present one op at an edge, check the previous one's outcome
	task automatic issue(rss_op_e o, logic [7:0] m, logic [2:0] b, logic v);
		logic [7:0] x;
		x = 8'($random(seed));
		@(posedge clock);
		op <= o;
		mem_rdata <= m;
		bit_sel <= b;
		imm <= x;
		op_valid <= v;
		#1;
		chk(accumulator_q, m_acc);
		chk({7'h00, carry_flag_q}, {7'h00, m_c});
		chk({4'h0, zero_flag_q, aux_carry_flag_q, overflow_flag_q, mem_we_q},
			{4'h0, m_z, m_ac, m_ov, e_we});
		if (e_we) begin
			chk(mem_wdata_q, e_wd);
		end
		chk({6'h00, squash_q, busy_q}, {6'h00, e_sq, e_sq});
		predict(o, v, m, x, b);
	endtask

	// Print counts and verdict, then stop
	task automatic final_report();
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Core clock, 5 ns period
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge clock);
		error_cnt++;
		final_report();
	end

	// Main sequence: corner cases, then random ops
	initial begin
		logic [31:0] r;
		rst = 1'b1;
		op_valid = 1'b0;
		op = RSS_OP_NONE;
		bit_sel = 3'h0;
		mem_rdata = 8'h00;
		imm = 8'h00;
		seed = 38003;
		error_cnt = 0;
		comparisons = 0;
		{m_acc, m_c, m_z, m_ac, m_ov, m_dummy, e_we, e_sq, e_wd} = '0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		issue(RSS_OP_DSZ_MEM, 8'h01, 3'h0, 1'b1);
		issue(RSS_OP_SET_BYTE, 8'h00, 3'h0, 1'b1);
		issue(RSS_OP_DSZ_ACC, 8'h01, 3'h0, 1'b1);
		issue(RSS_OP_ISZ_MEM, 8'hFF, 3'h0, 1'b1);
		issue(RSS_OP_ISZ_MEM, 8'hFF, 3'h0, 1'b1);
		issue(RSS_OP_ISZ_ACC, 8'hFF, 3'h0, 1'b1);
		issue(RSS_OP_SKIP_BIT, 8'h80, 3'h7, 1'b1);
		issue(RSS_OP_SKIP_BIT, 8'h7F, 3'h7, 1'b1);
		issue(RSS_OP_SET_BIT, 8'h7F, 3'h7, 1'b1);
		issue(RSS_OP_SUB_IMM, 8'h00, 3'h0, 1'b1);
		repeat (3000) begin
			r = $random(seed);
			issue(rss_op_e'(5'(r[15:8] % 21)), 8'($random(seed)), r[18:16],
				r[2:0] != 3'h0);
		end
		issue(RSS_OP_NONE, 8'h00, 3'h0, 1'b0);
		final_report();
	end
endmodule
